/* File: core/dram_ctrl_regs.svh */
/*
 Timing and field constants for the multiplexed bit-wide DRAM controller.
 Assumes a 100 MHz controller clock; included by its bare name.
*/
`ifndef DRAM_CTRL_REGS_SVH
`define DRAM_CTRL_REGS_SVH
`define CLK_PERIOD_NS 10
`define ROW_BITS 7
`define COL_BITS 7
`define ADDR_BITS 13
`define ROW_COUNT 128
`define REFRESH_MS 2
`define REFRESH_INTERVAL_NS (`REFRESH_MS * 1000000 / `ROW_COUNT)
`define REFRESH_CYC (`REFRESH_INTERVAL_NS / `CLK_PERIOD_NS)
`define INIT_CYCLES 8
`define T_ROW_SETUP_NS 30
`define T_ROW_SETUP_CYC ((`T_ROW_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_STROBE_LOW_NS 250
`define T_STROBE_LOW_CYC ((`T_STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_PRECHARGE_NS 150
`define T_PRECHARGE_CYC ((`T_PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WRITE_PULSE_NS 80
`define T_WRITE_PULSE_CYC ((`T_WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: core/dram_ctrl_pkg.sv */
/*
 Types for the multiplexed bit-wide DRAM controller.
 Assumes nothing beyond the standard language.
*/
package dram_ctrl_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ROW = 7'h02,
    ST_COL = 7'h04,
    ST_ACT = 7'h08,
    ST_WPULSE = 7'h10,
    ST_PRE = 7'h20,
    ST_REF = 7'h40
  } ctrl_state_e;
endpackage

/* File: core/dram_ctrl.sv */
/*
 Controller for an 8,192 x 1 dynamic RAM with a seven-line address bus.
 Holds request handshake, strobe sequencing, row-only refresh, power-up
 cycles. Assumes the memory answers on a separate data-out pin that may be
 shared with data-in; data-out arrives asynchronously and is synchronised.
*/
// Functional notes
// R1: Thirteen-bit address selects one of 8,192 cells
// R2: Row half driven, latched on row strobe fall
// R3: Column half driven, latched on column strobe fall
// R4: Half variant forces column bit zero
// R5: Address stable before each strobe falls
// R6: Row strobe acts as chip enable
// R7: Column strobe acts as chip select
// R8: Write enable high reads, low writes
// R9: Early write keeps data-out floating
// R10: Data captured on later strobe or write
// R11: Early write holds data-in across column fall
// R12: Delayed write holds data-in across write fall
// R13: Read data returned without inversion
// R14: Data-out floats until column strobe falls
// R15: Data-out valid while column strobe low
// R16: Delayed write drives output like read
// R17: Every row refreshed within two milliseconds
// R18: Refresh cycles row strobe, column strobe high
// R19: Row-only refresh produces no output
// R20: Inputs latched, data-out unlatched
// R21: Page mode reuses open row; the controller closes the row after every access
// R22: Eight cycles performed after power-up
// R23: Seven-bit refresh row counter advances per refresh
`timescale 1ns/1ps
`include "dram_ctrl_regs.svh"
module dram_ctrl
  import dram_ctrl_pkg::*;
#(
  parameter int REFRESH_CYC = `REFRESH_CYC,
  parameter bit HALF_ARRAY = 1'b0,
  parameter bit HALF_SIDE = 1'b0,
  parameter int ACCESS_CYC = `T_STROBE_LOW_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`ADDR_BITS-1:0] req_addr,
  input wire logic req_wdata,
  output logic rsp_valid,
  output logic rsp_rdata,
  output logic init_done,
  output logic [`ROW_BITS-1:0] mux_address_bus,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_en_n,
  output logic data_in,
  input wire logic data_out
);
  logic rst_s1_r, rst_n_r;
  logic q_s1_r, q_s2_r;
  ctrl_state_e state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] ref_cnt_r, ref_cnt_nxt;
  logic ref_due_r, ref_due_nxt;
  logic [`ROW_BITS-1:0] ref_row_r, ref_row_nxt;
  logic [3:0] init_r, init_nxt;
  logic [`ROW_BITS-1:0] addr_r, addr_nxt;
  logic ras_r, ras_nxt, cas_r, cas_nxt, we_r, we_nxt, d_r, d_nxt;
  logic [`ADDR_BITS-1:0] a_r, a_nxt;
  logic wr_r, wr_nxt, rv_r, rv_nxt, rd_r, rd_nxt;
  logic init_busy;

  // Column half with bit zero always pinned: to HALF_SIDE for half-array parts, to zero otherwise
  function automatic logic [`COL_BITS-1:0] col_of(
    input logic [`ADDR_BITS-1:0] a);
    logic [`COL_BITS-1:0] c;
    // Six upper address bits sit above the pinned bit zero
    c = {a[`ADDR_BITS-1:`ROW_BITS], 1'b0};
    if (HALF_ARRAY) begin
      c[0] = HALF_SIDE; // [R4]
    end
    return c;
  endfunction

  // Reset release through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Data-out is unlatched at the pin, so it is synchronised here
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      q_s1_r <= 1'b0;
      q_s2_r <= 1'b0;
    end else begin
      q_s1_r <= data_out; // [R20]
      q_s2_r <= q_s1_r;
    end
  end

  assign init_busy = (init_r != 4'(`INIT_CYCLES));
  assign req_ready = (state_r == ST_IDLE) && !ref_due_r && !init_busy;
  assign init_done = !init_busy;
  assign mux_address_bus = addr_r;
  assign row_strobe_n = ras_r;
  assign col_strobe_n = cas_r;
  assign write_en_n = we_r;
  assign data_in = d_r;
  assign rsp_valid = rv_r;
  assign rsp_rdata = rd_r;

  // Sequencer: refresh beats requests; power-up uses refresh cycles
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
    ref_cnt_nxt = ref_cnt_r + 16'h0001;
    ref_due_nxt = ref_due_r;
    ref_row_nxt = ref_row_r;
    init_nxt = init_r;
    addr_nxt = addr_r;
    ras_nxt = ras_r;
    cas_nxt = cas_r;
    we_nxt = we_r;
    d_nxt = d_r;
    a_nxt = a_r;
    wr_nxt = wr_r;
    rv_nxt = 1'b0;
    rd_nxt = rd_r;
    case (state_r)
      ST_IDLE: begin
        if (ref_due_r || init_busy) begin
          addr_nxt = ref_row_r; // [R18]
          cas_nxt = 1'b1; // [R19]
          cnt_nxt = 16'(`T_ROW_SETUP_CYC);
          state_nxt = ST_REF;
        end else if (req_valid) begin
          a_nxt = req_addr; // [R1]
          wr_nxt = req_write;
          addr_nxt = req_addr[`ROW_BITS-1:0]; // [R2] [R5]
          we_nxt = !req_write; // [R8] [R9]
          d_nxt = req_wdata; // [R11] [R12]
          cnt_nxt = 16'(`T_ROW_SETUP_CYC);
          state_nxt = ST_ROW;
        end
      end
      ST_ROW: begin
        if (cnt_r == 16'h0000) begin
          ras_nxt = 1'b0; // [R2] [R6]
          cnt_nxt = 16'(`T_ROW_SETUP_CYC);
          state_nxt = ST_COL;
        end
      end
      ST_COL: begin
        if (cnt_r == 16'h0001) begin
          addr_nxt = col_of(a_r); // [R3] [R5]
        end else if (cnt_r == 16'h0000) begin
          cas_nxt = 1'b0; // [R3] [R7] [R10]
          cnt_nxt = 16'(ACCESS_CYC);
          state_nxt = ST_ACT;
        end
      end
      ST_ACT: begin
        // Early write holds data-in through the whole strobe window
        if (cnt_r == 16'h0000) begin
          if (!wr_r) begin
            rd_nxt = q_s2_r; // [R13] [R14] [R15]
            rv_nxt = 1'b1;
          end else begin
            rv_nxt = 1'b1;
          end
          // Row closes after every access, so no page burst runs [R21]
          cas_nxt = 1'b1;
          ras_nxt = 1'b1;
          we_nxt = 1'b1;
          cnt_nxt = 16'(`T_PRECHARGE_CYC);
          state_nxt = ST_PRE;
        end
      end
      ST_WPULSE: begin
        state_nxt = ST_PRE;
      end
      ST_PRE: begin
        if (cnt_r == 16'h0000) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_REF: begin
        if (ras_r && cnt_r == 16'h0000) begin
          ras_nxt = 1'b0; // [R18]
          cnt_nxt = 16'(`T_STROBE_LOW_CYC);
        end else if (!ras_r && cnt_r == 16'h0000) begin
          ras_nxt = 1'b1;
          ref_row_nxt = ref_row_r + 7'h01; // [R23]
          ref_due_nxt = 1'b0;
          if (init_busy) begin
            init_nxt = init_r + 4'h1; // [R22]
          end
          cnt_nxt = 16'(`T_PRECHARGE_CYC);
          state_nxt = ST_PRE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Interval tick after the case, so a new tick beats a refresh clear
    if (ref_cnt_r >= 16'(REFRESH_CYC - 1)) begin
      ref_cnt_nxt = 16'h0000;
      ref_due_nxt = 1'b1; // [R17]
    end
  end

  // Registers of the sequencer
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      ref_cnt_r <= 16'h0000;
      ref_due_r <= 1'b0;
      ref_row_r <= 7'h00;
      init_r <= 4'h0;
      addr_r <= 7'h00;
      ras_r <= 1'b1;
      cas_r <= 1'b1;
      we_r <= 1'b1;
      d_r <= 1'b0;
      a_r <= 13'h0000;
      wr_r <= 1'b0;
      rv_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      ref_due_r <= ref_due_nxt;
      ref_row_r <= ref_row_nxt;
      init_r <= init_nxt;
      addr_r <= addr_nxt;
      ras_r <= ras_nxt;
      cas_r <= cas_nxt;
      we_r <= we_nxt;
      d_r <= d_nxt;
      a_r <= a_nxt;
      wr_r <= wr_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
    end
  end
endmodule // dram_ctrl

/* File: bench/dram_ctrl_monitor.sv */
/* Pin checker for the DRAM controller.
 Assumes it is bound to dram_ctrl and sees only its ports. */
`timescale 1ns/1ps
`include "dram_ctrl_regs.svh"
module dram_ctrl_monitor #(
  parameter int REFRESH_CYC = `REFRESH_CYC,
  parameter bit HALF_ARRAY = 1'b0,
  parameter bit HALF_SIDE = 1'b0
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic init_done,
  input wire logic [`ROW_BITS-1:0] mux_address_bus,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_en_n,
  input wire logic data_in
);
  int gap_r;
  int falls_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Cycles since the last row strobe, and row strobes since reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= 0;
      falls_r <= 0;
    end else begin
      gap_r <= $fell(row_strobe_n) ? 0 : gap_r + 1;
      falls_r <= falls_r + int'($fell(row_strobe_n));
    end
  end
  row_addr_set_a: assert property (
    $fell(row_strobe_n) |-> $stable(mux_address_bus) && col_strobe_n)
    else $error("row address moved at row strobe");
  col_addr_set_a: assert property (
    $fell(col_strobe_n) |-> $stable(mux_address_bus) && !row_strobe_n)
    else $error("column address moved at column strobe");
  col_bit_zero_a: assert property (
    $fell(col_strobe_n) && HALF_ARRAY |-> mux_address_bus[0] == HALF_SIDE)
    else $error("column bit zero wrong for half array");
  write_data_hold_a: assert property (
    !col_strobe_n |-> $stable(write_en_n) && $stable(data_in))
    else $error("write enable or data moved under column strobe");
  refresh_col_high_a: assert property (
    !init_done && !row_strobe_n |-> col_strobe_n)
    else $error("column strobe during power-up refresh");
  answer_bound_a: assert property (
    req_valid && req_ready |-> ##[8:60] rsp_valid)
    else $error("access never answered");
  refresh_gap_a: assert property (
    gap_r <= REFRESH_CYC + 64)
    else $error("row strobe missing too long");
  init_count_a: assert property (
    $rose(init_done) |-> falls_r == 8)
    else $error("power-up cycle count wrong");
  cover property (!write_en_n && $fell(col_strobe_n));
  cover property (write_en_n && $fell(col_strobe_n));
  cover property ($rose(init_done));
endmodule // dram_ctrl_monitor

bind dram_ctrl dram_ctrl_monitor #(.REFRESH_CYC(REFRESH_CYC),
  .HALF_ARRAY(HALF_ARRAY), .HALF_SIDE(HALF_SIDE)) mon_inst (.*);

/* File: bench/dram_model.sv */
/* Behavioural bit-wide DRAM facing the controller.
 Assumes ns time units; ACC_NS sets column access, slow or prompt. */
`timescale 1ns/1ps
`include "dram_ctrl_regs.svh"
module dram_model #(
  parameter int ACC_NS = 100
) (
  input wire logic [`ROW_BITS-1:0] mux_address_bus,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_en_n,
  input wire logic data_in,
  output logic data_out
);
  logic cells [0:16383];
  logic [6:0] row_r;
  logic [6:0] col_r;
  logic on = 1'b0;
  logic flip = 1'b0;
  // Row strobe latches the row and opens it
  always @(negedge row_strobe_n) row_r = mux_address_bus;
  // Column strobe selects the cell and the buffers
  always @(negedge col_strobe_n) begin
    col_r = mux_address_bus;
    if (!write_en_n) cells[{row_r, col_r}] = data_in;
    else on <= #(ACC_NS) 1'b1;
  end
  // Late write enable strobes the data instead
  always @(negedge write_en_n) begin
    if (!col_strobe_n) cells[{row_r, col_r}] = data_in;
  end
  // Output floats on column rise; refresh never enables it
  always @(posedge col_strobe_n) on <= 1'b0;
  // A floating line shows a moving pattern so stale bits never pass
  always #7 flip = ~flip;
  assign data_out = on ? cells[{row_r, col_r}] : flip;
endmodule // dram_model

/* File: bench/testbench.sv */
/* Random reads and writes checked against an associative-array model.
 Assumes controller, monitor and memory model are compiled first. */
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_wdata = 1'b0;
  logic [12:0] req_addr = 13'h0000;
  logic req_ready, rsp_valid, rsp_rdata, init_done, data_out;
  logic row_strobe_n, col_strobe_n, write_en_n, data_in;
  logic [6:0] mux_address_bus;
  int miscompares = 0;
  int samples_checked = 0;
  int unsigned seed = 31;
  logic mem [int];
  always #5 mclk = ~mclk;
  dram_ctrl #(.REFRESH_CYC(200), .HALF_ARRAY(1'b1), .HALF_SIDE(1'b1))
    dram_ctrl_inst (.*);
  dram_model dram_model_inst (.*);
  function automatic int unsigned xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(logic seen, logic exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One request held until taken, then wait for its answer
  task automatic access(logic wr, logic [12:0] a, logic d);
    int n;
    n = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    do @(negedge mclk); while (req_ready !== 1'b1 && ++n < 500);
    check(req_ready, 1'b1);
    @(posedge mclk);
    req_valid <= 1'b0;
    do @(negedge mclk); while (rsp_valid !== 1'b1 && ++n < 900);
    check(rsp_valid, 1'b1);
    if (!wr && mem.exists(a)) check(rsp_rdata, mem[a]);
    if (wr) mem[a] = d;
  endtask
  // Narrow address pool so reads hit earlier writes
  initial begin
    int unsigned r;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    wait (init_done === 1'b1);
    for (int i = 0; i < 80; i++) begin
      r = xorshift();
      // Address bit seven toggles too, so a lost column bit aliases cells
      access(r[0] | (i < 16), {r[3:1], 2'h0, r[10], 4'h0, r[6:4]},
        r[9]);
    end
    report_and_stop();
  end
  // Hang guard, well past the expected run
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
endmodule // testbench
